// >>> hw/vbs_pkg.sv
// constants shared by the vme buffer sequencer and its direction leaf
package vbs_pkg;
    localparam int  ADDR_STRAP_W      = 31;          // address pins 31 down to 1
    localparam int  DATA_STRAP_W      = 5;           // data pins 31 down to 27
    localparam int  DATA_STRAP_LSB    = 27;
    localparam int  DIR_CTL_CNT       = 6;           // direction controls other than address strobe
    localparam int  CLK_MHZ           = 125;
    localparam int  CORE_TICK_PS      = 15625;       // one 64 MHz period
    localparam int  CLK_PERIOD_PS     = 1000000 / CLK_MHZ;
    localparam int  TRISTATE_LEAD_CYC = (CORE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int  OE_HOLD_TICKS     = 8;           // core periods after system reset
    localparam int  OE_HOLD_CYC       = (OE_HOLD_TICKS * CORE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] OE_HOLD_LOAD = 8'(OE_HOLD_CYC);
    localparam logic [3:0] LEAD_LOAD    = 4'(TRISTATE_LEAD_CYC);
    localparam logic [30:0] ADDR_STRAP_RST = 31'h0000_0000;
    localparam logic [4:0]  DATA_STRAP_RST = 5'h00;
    localparam logic [2:0]  SYNC_RST       = 3'h0;
endpackage

// >>> hw/vbs_dir_leg.sv
// one direction-control leg: turns outward at once, inward only after the pad tri-state lead
`timescale 1ns/1ns
module vbs_dir_leg
    import vbs_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic want_out_in,
    output logic      pad_drive_out,
    output logic      dir_out
);
    logic [3:0] lead_r;

    // pads drop first, direction follows after the lead has run out
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pad_drive_out <= 1'b0;
            dir_out       <= 1'b0;
            lead_r        <= 4'h0;
        end
        else if (want_out_in)
        begin
            dir_out       <= 1'b1;
            pad_drive_out <= dir_out;                // pads only once buffers face out
            lead_r        <= LEAD_LOAD;
        end
        else
        begin
            pad_drive_out <= 1'b0;
            if (lead_r != 4'h0)
                lead_r <= lead_r - 4'h1;
            else
                dir_out <= 1'b0;
        end
    end
endmodule

// >>> hw/vbs_top.sv
// vme buffer sequencer: transceiver direction and enable control plus power-up strap capture
`timescale 1ns/1ns
// How it works
// - direction controls high while driving the bus, low while the bus drives us
// - address strobe direction is its own output, released independently
// - address and data pads go high impedance one 64 MHz period before their direction turns inward; control pads share one enable across all control groups
// - straps come from address pins 31..1 and data pins 31..27
// - undriven strap pins read low through internal pull-downs
// - address and data pins are never driven during any reset
// - transceiver enable stays negated during and some periods after system reset
// - straps latch at power-on reset rising edge with transceivers off
module vbs_top
    import vbs_pkg::*;
(
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      power_on_reset_n_in,
    input  wire logic                      sys_reset_n_in,
    input  wire logic                      drive_addr_in,
    input  wire logic                      drive_addr_modifier_in,
    input  wire logic                      drive_addr_strobe_in,
    input  wire logic                      drive_data_in,
    input  wire logic                      drive_data_strobe_in,
    input  wire logic                      drive_slave_resp_in,
    input  wire logic                      drive_syscon_in,
    input  wire logic [ADDR_STRAP_W-1:0]   vme_addr_pins_in,
    input  wire logic [DATA_STRAP_W-1:0]   vme_data_pins_in,
    output logic                           addr_dir_ctl_out,
    output logic                           addr_modifier_dir_ctl_out,
    output logic                           addr_strobe_dir_ctl_out,
    output logic                           data_dir_ctl_out,
    output logic                           data_strobe_dir_ctl_out,
    output logic                           slave_resp_dir_ctl_out,
    output logic                           syscon_dir_ctl_out,
    output logic                           addr_pins_oe_out,
    output logic                           data_pins_oe_out,
    output logic                           ctl_pins_oe_out,
    output logic                           xcvr_out_enable_n_out,
    output logic [ADDR_STRAP_W-1:0]        addr_strap_out,
    output logic [DATA_STRAP_W-1:0]        data_strap_out,
    output logic                           strap_valid_out
);
    logic       rst_sync1_r;
    logic       rst_sync2_r;
    logic [2:0] por_sync_r;
    logic [2:0] sys_sync_r;
    logic       por_n_r;
    logic       sys_n_r;
    logic [7:0] oe_hold_r;
    logic       in_reset;
    logic [DIR_CTL_CNT-1:0] want_out;
    logic [DIR_CTL_CNT-1:0] pad_drv;
    logic [DIR_CTL_CNT-1:0] dir_q;
    logic       as_pad;
    logic       as_dir;
    logic [ADDR_STRAP_W-1:0] addr_pin_s1_r;
    logic [ADDR_STRAP_W-1:0] addr_pin_s2_r;
    logic [ADDR_STRAP_W-1:0] addr_pin_s3_r;
    logic [ADDR_STRAP_W-1:0] addr_pin_r;
    logic [DATA_STRAP_W-1:0] data_pin_s1_r;
    logic [DATA_STRAP_W-1:0] data_pin_s2_r;
    logic [DATA_STRAP_W-1:0] data_pin_s3_r;
    logic [DATA_STRAP_W-1:0] data_pin_r;

    // local reset released through two flip-flops
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    // reset pins are asynchronous: three stages, a change counts when the last two agree
    always_ff @(posedge clock_in or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            por_sync_r <= SYNC_RST;
            sys_sync_r <= SYNC_RST;
            por_n_r    <= 1'b0;
            sys_n_r    <= 1'b0;
        end
        else
        begin
            por_sync_r <= {por_sync_r[1:0], power_on_reset_n_in};
            sys_sync_r <= {sys_sync_r[1:0], sys_reset_n_in};
            if (por_sync_r[2] == por_sync_r[1])
                por_n_r <= por_sync_r[2];
            if (sys_sync_r[2] == sys_sync_r[1])
                sys_n_r <= sys_sync_r[2];
        end
    end

    // any reset event counts; pins stay released throughout
    assign in_reset = !por_n_r || !sys_n_r;

    // strap pins sit outside the clock domain: three stages per bit, and a bit only moves
    // once the last two stages agree, so a pin that is still settling never gets latched
    always_ff @(posedge clock_in or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            addr_pin_s1_r <= ADDR_STRAP_RST;
            addr_pin_s2_r <= ADDR_STRAP_RST;
            addr_pin_s3_r <= ADDR_STRAP_RST;
            addr_pin_r    <= ADDR_STRAP_RST;
            data_pin_s1_r <= DATA_STRAP_RST;
            data_pin_s2_r <= DATA_STRAP_RST;
            data_pin_s3_r <= DATA_STRAP_RST;
            data_pin_r    <= DATA_STRAP_RST;
        end
        else
        begin
            addr_pin_s1_r <= vme_addr_pins_in;
            addr_pin_s2_r <= addr_pin_s1_r;
            addr_pin_s3_r <= addr_pin_s2_r;
            addr_pin_r    <= (addr_pin_s3_r & ~(addr_pin_s2_r ^ addr_pin_s3_r))
                             | (addr_pin_r & (addr_pin_s2_r ^ addr_pin_s3_r));
            data_pin_s1_r <= vme_data_pins_in;
            data_pin_s2_r <= data_pin_s1_r;
            data_pin_s3_r <= data_pin_s2_r;
            data_pin_r    <= (data_pin_s3_r & ~(data_pin_s2_r ^ data_pin_s3_r))
                             | (data_pin_r & (data_pin_s2_r ^ data_pin_s3_r));
        end
    end

    // strap capture at the filtered power-on rising edge; transceivers are still held off then
    always_ff @(posedge clock_in or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            addr_strap_out  <= ADDR_STRAP_RST;
            data_strap_out  <= DATA_STRAP_RST;
            strap_valid_out <= 1'b0;
        end
        else if (!por_n_r && por_sync_r[2] && por_sync_r[1])
        begin
            addr_strap_out  <= addr_pin_r;           // pull-downs give zeros when open
            data_strap_out  <= data_pin_r;
            strap_valid_out <= 1'b1;
        end
    end

    // enable stays negated through reset and a hold afterwards, so straps can be removed first
    always_ff @(posedge clock_in or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            oe_hold_r             <= OE_HOLD_LOAD;
            xcvr_out_enable_n_out <= 1'b1;
        end
        else if (in_reset)
        begin
            oe_hold_r             <= OE_HOLD_LOAD;
            xcvr_out_enable_n_out <= 1'b1;
        end
        else if (oe_hold_r != 8'h00)
        begin
            oe_hold_r             <= oe_hold_r - 8'h01;
            xcvr_out_enable_n_out <= 1'b1;
        end
        else
            xcvr_out_enable_n_out <= 1'b0;
    end

    // requests are masked during reset so no direction turns outward
    assign want_out = {drive_syscon_in, drive_slave_resp_in, drive_data_strobe_in,
                       drive_data_in, drive_addr_modifier_in, drive_addr_in} & {DIR_CTL_CNT{!in_reset}};

    // one leg for each grouped direction control
    genvar gi;
    generate
        for (gi = 0; gi < DIR_CTL_CNT; gi++)
        begin : g_leg
            vbs_dir_leg u_leg (
                .clock_in      (clock_in),
                .rst_b_in      (rst_sync2_r),
                .want_out_in   (want_out[gi]),
                .pad_drive_out (pad_drv[gi]),
                .dir_out       (dir_q[gi])
            );
        end
    endgenerate

    // address strobe leg runs alone so early bus release does not wait on the rest
    vbs_dir_leg u_as_leg (
        .clock_in      (clock_in),
        .rst_b_in      (rst_sync2_r),
        .want_out_in   (drive_addr_strobe_in && !in_reset),
        .pad_drive_out (as_pad),
        .dir_out       (as_dir)
    );

    // registered copies so every output leaves from a flip-flop
    always_ff @(posedge clock_in or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            addr_dir_ctl_out          <= 1'b0;
            addr_modifier_dir_ctl_out <= 1'b0;
            addr_strobe_dir_ctl_out   <= 1'b0;
            data_dir_ctl_out          <= 1'b0;
            data_strobe_dir_ctl_out   <= 1'b0;
            slave_resp_dir_ctl_out    <= 1'b0;
            syscon_dir_ctl_out        <= 1'b0;
            addr_pins_oe_out          <= 1'b0;
            data_pins_oe_out          <= 1'b0;
            ctl_pins_oe_out           <= 1'b0;
        end
        else
        begin
            addr_dir_ctl_out          <= dir_q[0];
            addr_modifier_dir_ctl_out <= dir_q[1];
            data_dir_ctl_out          <= dir_q[2];
            data_strobe_dir_ctl_out   <= dir_q[3];
            slave_resp_dir_ctl_out    <= dir_q[4];
            syscon_dir_ctl_out        <= dir_q[5];
            addr_strobe_dir_ctl_out   <= as_dir;
            addr_pins_oe_out          <= pad_drv[0] && !in_reset;
            data_pins_oe_out          <= pad_drv[2] && !in_reset;
            ctl_pins_oe_out           <= (as_pad || pad_drv[1] || pad_drv[3] || pad_drv[4] || pad_drv[5])
                                         && !in_reset;
        end
    end
endmodule

// >>> testbench/vbs_top_props.sv
// concurrent checks on the vme buffer sequencer ports
`timescale 1ns/1ns
module vbs_top_props
    import vbs_pkg::*;
(
    input wire logic                    clock_in,
    input wire logic                    rst_b_in,
    input wire logic                    power_on_reset_n_in,
    input wire logic                    sys_reset_n_in,
    input wire logic                    drive_addr_strobe_in,
    input wire logic                    drive_data_in,
    input wire logic [ADDR_STRAP_W-1:0] vme_addr_pins_in,
    input wire logic                    addr_dir_ctl_out,
    input wire logic                    addr_strobe_dir_ctl_out,
    input wire logic                    data_dir_ctl_out,
    input wire logic                    addr_pins_oe_out,
    input wire logic                    data_pins_oe_out,
    input wire logic                    xcvr_out_enable_n_out,
    input wire logic [ADDR_STRAP_W-1:0] addr_strap_out,
    input wire logic                    strap_valid_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // enable asserted means no reset window is open, so requests are live
    a_dir_then_oe: assert property ($rose(drive_data_in) && !xcvr_out_enable_n_out
        |-> ##2 data_dir_ctl_out ##1 data_pins_oe_out) else $error("data direction or drive late");
    a_tristate_lead: assert property ($fell(drive_data_in) && !xcvr_out_enable_n_out
        |-> ##2 !data_pins_oe_out && data_dir_ctl_out ##1 data_dir_ctl_out) else $error("turned before tristate");
    a_strobe_own: assert property ($rose(drive_addr_strobe_in) && !xcvr_out_enable_n_out
        |-> ##2 addr_strobe_dir_ctl_out) else $error("strobe direction late");
    a_oe_needs_dir: assert property (addr_pins_oe_out |-> addr_dir_ctl_out)
        else $error("address pins driven facing inward");
    a_sys_undriven: assert property (!sys_reset_n_in [*6] |-> !addr_pins_oe_out && !data_pins_oe_out)
        else $error("pins driven in system reset");
    a_por_undriven: assert property (!power_on_reset_n_in [*6]
        |-> !addr_pins_oe_out && !data_pins_oe_out && xcvr_out_enable_n_out) else $error("active in power reset");
    a_enable_hold: assert property ($rose(sys_reset_n_in) |-> xcvr_out_enable_n_out [*8])
        else $error("transceivers enabled too soon");
    a_strap_take: assert property ($rose(strap_valid_out)
        |-> xcvr_out_enable_n_out && addr_strap_out == $past(vme_addr_pins_in)) else $error("strap capture bad");
    c_capture: cover property ($rose(strap_valid_out));
    c_turn_in: cover property ($fell(data_dir_ctl_out));
    c_sys_end: cover property ($rose(sys_reset_n_in));
endmodule

// >>> testbench/vbs_strap_model.sv
// strap driver model: option values on the pins only while the transceivers are disabled
`timescale 1ns/1ns
module vbs_strap_model
    import vbs_pkg::*;
(
    input  wire logic                    clock_in,
    input  wire logic                    xcvr_out_enable_n_in,
    input  wire logic [ADDR_STRAP_W-1:0] addr_opt_in,
    input  wire logic [DATA_STRAP_W-1:0] data_opt_in,
    output logic      [ADDR_STRAP_W-1:0] vme_addr_pins_out,
    output logic      [DATA_STRAP_W-1:0] vme_data_pins_out,
    output logic                         xcvr_gate_n_out
);
    logic gate_dly_r = 1'b1;
    logic gate_n_r   = 1'b1;

    // let go as soon as enable asserts; a released pin reads the pull-down low
    assign vme_addr_pins_out = xcvr_out_enable_n_in ? addr_opt_in : '0;
    assign vme_data_pins_out = xcvr_out_enable_n_in ? data_opt_in : '0;
    // transceivers open two clocked latches after the straps are gone; negation shuts them at the next clock edge
    always @(posedge clock_in)
    begin
        gate_dly_r <= xcvr_out_enable_n_in;
        gate_n_r   <= gate_dly_r || xcvr_out_enable_n_in;
    end
    assign xcvr_gate_n_out = gate_n_r;
endmodule

// >>> testbench/test_vbs_top.sv
// bench for the vme buffer sequencer: strap capture, direction order, reset windows
`timescale 1ns/1ns
module test_vbs_top
    import vbs_pkg::*;
;
    logic                    clock_in = 1'b0;
    logic                    rst_b_in = 1'b0;
    logic                    por_n    = 1'b0;
    logic                    sys_n    = 1'b0;
    logic [6:0]              drv      = 7'h00;
    logic [ADDR_STRAP_W-1:0] a_opt    = '0;
    logic [DATA_STRAP_W-1:0] d_opt    = '0;
    logic [ADDR_STRAP_W-1:0] a_pin, a_strap;
    logic [DATA_STRAP_W-1:0] d_pin, d_strap;
    logic [6:0]              dir;
    logic                    a_oe, d_oe, c_oe, oe_n, s_vld, x_gate_n;
    int                      miscompares = 0;
    int                      n_compared  = 0;
    always #4 clock_in = ~clock_in;
    vbs_strap_model u_strap (.clock_in(clock_in), .xcvr_out_enable_n_in(oe_n), .addr_opt_in(a_opt),
        .data_opt_in(d_opt), .vme_addr_pins_out(a_pin), .vme_data_pins_out(d_pin),
        .xcvr_gate_n_out(x_gate_n));
    vbs_top i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .power_on_reset_n_in(por_n),
        .sys_reset_n_in(sys_n), .drive_addr_in(drv[0]), .drive_addr_modifier_in(drv[1]),
        .drive_addr_strobe_in(drv[2]), .drive_data_in(drv[3]), .drive_data_strobe_in(drv[4]),
        .drive_slave_resp_in(drv[5]), .drive_syscon_in(drv[6]), .vme_addr_pins_in(a_pin),
        .vme_data_pins_in(d_pin), .addr_dir_ctl_out(dir[0]), .addr_modifier_dir_ctl_out(dir[1]),
        .addr_strobe_dir_ctl_out(dir[2]), .data_dir_ctl_out(dir[3]), .data_strobe_dir_ctl_out(dir[4]),
        .slave_resp_dir_ctl_out(dir[5]), .syscon_dir_ctl_out(dir[6]), .addr_pins_oe_out(a_oe),
        .data_pins_oe_out(d_oe), .ctl_pins_oe_out(c_oe), .xcvr_out_enable_n_out(oe_n),
        .addr_strap_out(a_strap), .data_strap_out(d_strap), .strap_valid_out(s_vld));
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // inputs always move 1 ns after the edge so the design never samples a race
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // straps held across the rising edge, requests refused while in reset
    task automatic por_capture(input logic [35:0] v);
        int k;
        {a_opt, d_opt} = v;
        por_n = 1'b0;
        sys_n = 1'b0;
        drv = 7'h7F;
        tick(8);
        chk("pins in reset", 36'h0, {c_oe, d_oe, a_oe});
        drv = 7'h00;
        por_n = 1'b1;
        sys_n = 1'b1;
        tick(8);
        chk("straps", v, {a_strap, d_strap});
        chk("strap valid", 36'h1, s_vld);
        for (k = 8; k < 80 && oe_n !== 1'b0; k++) tick(1);
        chk("enable hold", 36'h1, 36'(k >= OE_HOLD_CYC && k < 80));
        chk("pins freed", 36'h0, {a_pin, d_pin});
        chk("gate still shut", 36'h1, x_gate_n);
        tick(2);
        chk("gate opened", 36'h0, x_gate_n);
    endtask
    // one group out and back: pins driven only after facing out, released before facing in
    task automatic group_cycle(input int i);
        int k;
        drv[i] = 1'b1;
        for (k = 0; k < 8 && dir[i] !== 1'b1; k++) tick(1);
        chk("dir out", 36'h1 << i, dir);
        chk("oe before dir", 36'h0, {c_oe, d_oe, a_oe});
        tick(1);
        chk("pins driven", (i == 0) ? 36'h1 : (i == 3) ? 36'h2 : 36'h4, {c_oe, d_oe, a_oe});
        drv[i] = 1'b0;
        for (k = 0; k < 8 && {c_oe, d_oe, a_oe} !== 3'h0; k++) tick(1);
        tick(1);
        chk("dir after tristate", 36'h1 << i, dir);
        tick(6);
        chk("dir in", 36'h0, dir);
    endtask
    // system reset lands in mid-transfer, then the enable must stay off for the hold span
    task automatic sys_reset_mid();
        int k;
        drv = 7'h0D;
        tick(6);
        drv = 7'h09;
        tick(6);
        chk("strobe released alone", 36'h9, dir);
        sys_n = 1'b0;
        tick(8);
        chk("pins in sys reset", 36'h1, {c_oe, d_oe, a_oe, oe_n});
        drv = 7'h00;
        sys_n = 1'b1;
        for (k = 0; k < 80 && oe_n !== 1'b0; k++) tick(1);
        chk("sys hold", 36'h1, 36'(k >= OE_HOLD_CYC && k < 80));
    endtask
    task automatic end_of_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        tick(16);
        rst_b_in = 1'b1;
        tick(4);
        chk("no straps yet", 36'h0, s_vld);
        por_capture(36'h5_5555_5555);
        por_capture(36'hA_AAAA_AAAA);
        for (int i = 0; i < 7; i++) group_cycle(i);
        sys_reset_mid();
        end_of_test();
    end
    // the whole sequence needs well under 2000 cycles
    initial
    begin
        #40000;
        miscompares++;
        end_of_test();
    end
endmodule
bind vbs_top vbs_top_props i_props (.*);
